// file: rtl/legacy_regs_pkg.sv
// Constants for the legacy trap, wake enable and host I/O register block.
// Assumes one clock domain and register access through the documented spaces.
package legacy_regs_pkg;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_HOST_COMMAND    = 8'h00;
    localparam logic [7:0] OFS_HOST_STATUS     = 8'h02;
    localparam logic [7:0] OFS_INTERRUPT_EN    = 8'h04;
    localparam logic [7:0] OFS_FRAME_NUMBER    = 8'h06;
    localparam logic [7:0] OFS_FRAME_LIST_BASE = 8'h08;
    localparam logic [7:0] OFS_SOF_ADJUST      = 8'h0C;
    localparam logic [7:0] OFS_PORT_A_SC       = 8'h10;
    localparam logic [7:0] OFS_PORT_B_SC       = 8'h12;
    localparam logic [7:0] OFS_LOOPBACK        = 8'h18;
    localparam logic [7:0] OFS_WAKE_ENABLE     = 8'hC4;
    localparam logic [7:0] OFS_LEGACY_CTRL     = 8'hC0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] RST_HOST_COMMAND = 16'h0000;
    localparam logic [15:0] RST_HOST_STATUS  = 16'h0020;
    localparam logic [15:0] RST_INTERRUPT_EN = 16'h0000;
    localparam logic [15:0] RST_FRAME_NUMBER = 16'h0000;
    localparam logic [7:0]  RST_SOF_ADJUST   = 8'h40;
    localparam logic [15:0] RST_PORT_SC      = 16'h0080;
    localparam logic [7:0]  RST_WAKE_ENABLE  = 8'h00;
    localparam logic [15:0] RST_LEGACY_CTRL  = 16'h0000;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_DATA_RD_EN  = 0;
    localparam int BIT_DATA_WR_EN  = 1;
    localparam int BIT_CMD_RD_EN   = 2;
    localparam int BIT_CMD_WR_EN   = 3;
    localparam int BIT_IRQ_SMI_EN  = 4;
    localparam int BIT_DATA_RD_ST  = 8;
    localparam int BIT_DATA_WR_ST  = 9;
    localparam int BIT_CMD_RD_ST   = 10;
    localparam int BIT_CMD_WR_ST   = 11;
    localparam int BIT_GLOBAL_RES  = 4;   // Command: global resume
    localparam int BIT_HC_RESET    = 1;   // Command: host controller reset
    localparam int BIT_GLB_RESET   = 2;   // Command: global reset
    localparam int BIT_PORT_ENABLE = 2;   // Port: enabled
    localparam int BIT_RESUME_DET  = 6;   // Port: resume detect
    localparam int BIT_PORT_RESET  = 9;   // Port: port reset
    localparam int BIT_SUSPEND     = 12;  // Port: suspend

endpackage

// file: rtl/usb_legacy_smi_wake_regs.sv
// Legacy trap SMI routing, per-port wake enables and host controller I/O registers.
// Assumes synchronous register strobes on clock; trap and port events are pins.
// ************************************************************
// Function
// - A controller interrupt raises SMI only while the interrupt SMI enable is 1.
// - Command port write trap status raises SMI only while its enable (bit 3) is 1.
// - Command port read trap status raises SMI only while its enable (bit 2) is 1.
// - Data port write trap status raises SMI only while its enable (bit 1) is 1.
// - Data port read trap status raises SMI only while its enable (bit 0) is 1.
// - A port whose wake enable is 1 is watched for wakeup, connect and disconnect.
// - Wake bit 1 serves the second port, bit 0 the first, bits 7:2 read zero.
// - Port enable bit 2 reads back the written value ANDed with the live port state.
// - Controller, global or port reset ends transfers and disables affected ports.
// - Controller and global reset clear command bit 4; all three clear port bits 12, 6 and 2.
// - Start of frame adjust resets to 40h; the frame list base has no set reset.
// - Each trap status sets on its event regardless of enable, cleared by writing 1.
module usb_legacy_smi_wake_regs
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        clock_enable,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [1:0]  reg_byte_en,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    input  wire logic        usb_irq,
    input  wire logic [3:0]  trap_event,
    input  wire logic [1:0]  port_wake_event,
    input  wire logic [1:0]  port_enabled_live,
    output logic             smi_request,
    output logic             wake_request,
    output logic [1:0]       port_disable,
    output logic             transfer_abort
);
    import legacy_regs_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;

    // Two flops for every pin-sourced level except usb_irq, which is used unsynchronised
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else if (clock_enable) begin
            pin_meta_reg <= {port_enabled_live, port_wake_event, trap_event};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic [3:0] trap_sync;
    logic [1:0] wake_sync;
    logic [1:0] live_sync;
    assign trap_sync = pin_sync_reg[3:0];
    assign wake_sync = pin_sync_reg[5:4];
    assign live_sync = pin_sync_reg[7:6];

    // Edge detect on trap events so a held pin sets status once
    logic [3:0] trap_prev_reg;
    logic [3:0] trap_rise;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            trap_prev_reg <= 4'h0;
        end else if (clock_enable) begin
            trap_prev_reg <= trap_sync;
        end
    end
    assign trap_rise = trap_sync & ~trap_prev_reg;

    // ************************************************************
    // Write decode helpers
    // ************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    logic wr;
    logic whole_word;
    assign wr         = reg_write & clock_enable;
    assign whole_word = (reg_byte_en == 2'h3);

    // ************************************************************
    // Legacy trap control and status
    // ************************************************************
    logic [15:0] legacy_ctrl_reg;
    logic        clr_status;
    assign clr_status = wr && hit(reg_addr, OFS_LEGACY_CTRL);

    // Enables are plain read/write; status bits set on events, write 1 clears
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            legacy_ctrl_reg <= RST_LEGACY_CTRL;
        end else if (clock_enable) begin
            for (int i = 0; i < 5; i++) begin
                if (clr_status && reg_byte_en[0]) begin
                    legacy_ctrl_reg[i] <= reg_wdata[i];
                end
            end
            for (int i = 0; i < 4; i++) begin
                // Set wins over a simultaneous clear
                if (trap_rise[i]) begin
                    legacy_ctrl_reg[BIT_DATA_RD_ST + i] <= 1'b1;
                end else if (clr_status && reg_byte_en[1] && reg_wdata[BIT_DATA_RD_ST + i]) begin
                    legacy_ctrl_reg[BIT_DATA_RD_ST + i] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Host command, status and frame registers
    // ************************************************************
    logic [15:0] host_command_reg;
    logic [15:0] host_status_reg;
    logic [15:0] interrupt_enable_reg;
    logic [15:0] frame_number_reg;
    logic [31:0] frame_list_base_reg;
    logic [7:0]  sof_timing_adjust_reg;
    logic [7:0]  loopback_capture_reg;
    logic [7:0]  port_wake_enable_reg;
    logic        hc_reset;
    logic        glb_reset;

    assign hc_reset  = host_command_reg[BIT_HC_RESET];
    assign glb_reset = host_command_reg[BIT_GLB_RESET];

    // Command: the controller reset bit self-clears; resets drop global resume
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            host_command_reg <= RST_HOST_COMMAND;
        end else if (clock_enable) begin
            if (wr && hit(reg_addr, OFS_HOST_COMMAND)) begin
                host_command_reg <= merge16(host_command_reg, reg_wdata[15:0], reg_byte_en);
            end else begin
                host_command_reg[BIT_HC_RESET] <= 1'b0;
            end
            if (hc_reset || glb_reset) begin
                host_command_reg[BIT_GLOBAL_RES] <= 1'b0;
            end
        end
    end

    // Status: the IRQ input sets bit 0, writing 1 clears it; other bits keep their reset value
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            host_status_reg <= RST_HOST_STATUS;
        end else if (clock_enable) begin
            if (usb_irq) begin
                host_status_reg[0] <= 1'b1;
            end else if (wr && hit(reg_addr, OFS_HOST_STATUS) && reg_byte_en[0]
                         && reg_wdata[0]) begin
                host_status_reg[0] <= 1'b0;
            end
        end
    end

    // Plain read/write registers except loopback capture, which is never written; frame number takes whole words only; wake enable bits 7:2 stay zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            interrupt_enable_reg  <= RST_INTERRUPT_EN;
            frame_number_reg      <= RST_FRAME_NUMBER;
            sof_timing_adjust_reg <= RST_SOF_ADJUST;
            port_wake_enable_reg  <= RST_WAKE_ENABLE;
            loopback_capture_reg  <= 8'h00;
        end else if (clock_enable) begin
            if (wr && hit(reg_addr, OFS_INTERRUPT_EN)) begin
                interrupt_enable_reg <= merge16(interrupt_enable_reg, reg_wdata[15:0],
                                                reg_byte_en);
            end
            if (wr && hit(reg_addr, OFS_FRAME_NUMBER) && whole_word) begin
                frame_number_reg <= reg_wdata[15:0];
            end
            if (wr && hit(reg_addr, OFS_SOF_ADJUST) && reg_byte_en[0]) begin
                sof_timing_adjust_reg <= reg_wdata[7:0];
            end
            if (wr && hit(reg_addr, OFS_WAKE_ENABLE) && reg_byte_en[0]) begin
                port_wake_enable_reg <= {6'h00, reg_wdata[1:0]};
            end
        end
    end

    // Frame list base carries no reset value
    always_ff @(posedge clock) begin
        if (clock_enable && wr && hit(reg_addr, OFS_FRAME_LIST_BASE)) begin
            frame_list_base_reg <= reg_wdata;
        end
    end

    // ************************************************************
    // Port status and control
    // ************************************************************
    logic [15:0] port_sc_reg [2];
    logic [1:0]  port_reset;

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            port_reset[p] = port_sc_reg[p][BIT_PORT_RESET];
        end
    end

    // Whole-word writes only; resets clear bits 12, 6 and 2
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            port_sc_reg[0] <= RST_PORT_SC;
            port_sc_reg[1] <= RST_PORT_SC;
        end else if (clock_enable) begin
            for (int p = 0; p < 2; p++) begin
                if (wr && whole_word &&
                    hit(reg_addr, p == 0 ? OFS_PORT_A_SC : OFS_PORT_B_SC)) begin
                    port_sc_reg[p] <= reg_wdata[15:0];
                end
                if (hc_reset || glb_reset || port_reset[p]) begin
                    port_sc_reg[p][BIT_SUSPEND]     <= 1'b0;
                    port_sc_reg[p][BIT_RESUME_DET]  <= 1'b0;
                    port_sc_reg[p][BIT_PORT_ENABLE] <= 1'b0;
                end
            end
        end
    end

    // Read value shows the written enable ANDed with the live enable state of the port
    function automatic logic [15:0] port_view(input logic [15:0] r, input logic live);
        port_view = r;
        port_view[BIT_PORT_ENABLE] = r[BIT_PORT_ENABLE] & live;
    endfunction

    // ************************************************************
    // Read mux
    // ************************************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (clock_enable && reg_read) begin
            if (hit(reg_addr, OFS_HOST_COMMAND)) begin
                reg_rdata <= {16'h0000, host_command_reg};
            end else if (hit(reg_addr, OFS_HOST_STATUS)) begin
                reg_rdata <= {16'h0000, host_status_reg};
            end else if (hit(reg_addr, OFS_INTERRUPT_EN)) begin
                reg_rdata <= {16'h0000, interrupt_enable_reg};
            end else if (hit(reg_addr, OFS_FRAME_NUMBER)) begin
                reg_rdata <= {16'h0000, frame_number_reg};
            end else if (hit(reg_addr, OFS_FRAME_LIST_BASE)) begin
                reg_rdata <= frame_list_base_reg;
            end else if (hit(reg_addr, OFS_SOF_ADJUST)) begin
                reg_rdata <= {24'h000000, sof_timing_adjust_reg};
            end else if (hit(reg_addr, OFS_PORT_A_SC)) begin
                reg_rdata <= {16'h0000, port_view(port_sc_reg[0], live_sync[0])};
            end else if (hit(reg_addr, OFS_PORT_B_SC)) begin
                reg_rdata <= {16'h0000, port_view(port_sc_reg[1], live_sync[1])};
            end else if (hit(reg_addr, OFS_LOOPBACK)) begin
                reg_rdata <= {24'h000000, loopback_capture_reg};
            end else if (hit(reg_addr, OFS_LEGACY_CTRL)) begin
                reg_rdata <= {16'h0000, legacy_ctrl_reg};
            end else if (hit(reg_addr, OFS_WAKE_ENABLE)) begin
                reg_rdata <= {24'h000000, port_wake_enable_reg};
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // SMI, wake and reset outputs
    // ************************************************************
    logic [3:0] trap_hits;
    logic       smi_next;
    assign trap_hits = legacy_ctrl_reg[11:8] & legacy_ctrl_reg[3:0];
    assign smi_next  = (|trap_hits) | (usb_irq & legacy_ctrl_reg[BIT_IRQ_SMI_EN]);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            smi_request    <= 1'b0;
            wake_request   <= 1'b0;
            port_disable   <= 2'h0;
            transfer_abort <= 1'b0;
        end else if (clock_enable) begin
            smi_request    <= smi_next;
            wake_request   <= |(wake_sync & port_wake_enable_reg[1:0]);
            port_disable   <= port_reset | {2{hc_reset | glb_reset}};
            transfer_abort <= hc_reset | glb_reset | (|port_reset);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Routing, status, wake and reset checks
    a_smi_irq_route: assert property (@(posedge clock) disable iff (!resetn)
        clock_enable && usb_irq && legacy_ctrl_reg[BIT_IRQ_SMI_EN] |=> smi_request)
        else $error("irq with smi enable did not raise smi");
    a_smi_gated: assert property (@(posedge clock) disable iff (!resetn)
        clock_enable && !usb_irq && trap_hits == 4'h0 |=> !smi_request)
        else $error("smi raised without enabled source");
    a_smi_trap_route: assert property (@(posedge clock) disable iff (!resetn)
        clock_enable && trap_hits != 4'h0 |=> smi_request)
        else $error("enabled trap status did not raise smi");
    a_trap_sticky: assert property (@(posedge clock) disable iff (!resetn)
        clock_enable && trap_rise[3] |=> legacy_ctrl_reg[BIT_CMD_WR_ST])
        else $error("trap status not set");
    a_irq_status: assert property (@(posedge clock) disable iff (!resetn)
        clock_enable && usb_irq |=> host_status_reg[0])
        else $error("controller interrupt not recorded in status");
    a_wake_gate: assert property (@(posedge clock) disable iff (!resetn)
        clock_enable && port_wake_enable_reg[1:0] == 2'h0 |=> !wake_request)
        else $error("wake without enable");
    a_wake_reserved: assert property (@(posedge clock) disable iff (!resetn)
        port_wake_enable_reg[7:2] == 6'h00)
        else $error("reserved wake bits set");
    a_frame_word: assert property (@(posedge clock) disable iff (!resetn)
        clock_enable && reg_write && reg_addr == OFS_FRAME_NUMBER && reg_byte_en != 2'h3
        |=> $stable(frame_number_reg))
        else $error("frame number took a partial write");
    a_reset_disable: assert property (@(posedge clock) disable iff (!resetn)
        clock_enable && hc_reset |=> port_disable == 2'h3 && transfer_abort)
        else $error("controller reset did not disable ports");
    a_port_reset_off: assert property (@(posedge clock) disable iff (!resetn)
        clock_enable && port_reset[1] |=> port_disable[1] && !port_sc_reg[1][BIT_PORT_ENABLE])
        else $error("port reset did not disable its port");
    a_reset_resume: assert property (@(posedge clock) disable iff (!resetn)
        clock_enable && glb_reset |=> !host_command_reg[BIT_GLOBAL_RES])
        else $error("global resume not cleared");
    a_sof_reset: assert property (@(posedge clock)
        $rose(resetn) |-> sof_timing_adjust_reg == RST_SOF_ADJUST)
        else $error("sof adjust reset value wrong");

    // Cover points for the main scenarios
    c_smi_seen: cover property (@(posedge clock) disable iff (!resetn) $rose(smi_request));
    c_trap_set: cover property (@(posedge clock) disable iff (!resetn)
        $rose(legacy_ctrl_reg[BIT_CMD_WR_ST]));
    c_global_reset: cover property (@(posedge clock) disable iff (!resetn) $rose(glb_reset));
    c_wake_seen: cover property (@(posedge clock) disable iff (!resetn) $rose(wake_request));
    c_port_reset: cover property (@(posedge clock) disable iff (!resetn) $rose(transfer_abort));
endmodule

// file: bench/usb_legacy_smi_wake_regs_tb.sv
// Self-checking bench for the legacy trap, wake enable and host register block.
// Assumes the design package is compiled first; bench drives all pins itself.
module usb_legacy_smi_wake_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import legacy_regs_pkg::*;

    // ************************************************************
    // Signals
    // ************************************************************
    logic        clock;
    logic        resetn;
    logic        clock_enable;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  reg_addr;
    logic [1:0]  reg_byte_en;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        usb_irq;
    logic [3:0]  trap_event;
    logic [1:0]  port_wake_event;
    logic [1:0]  port_enabled_live;
    logic        smi_request;
    logic        wake_request;
    logic [1:0]  port_disable;
    logic        transfer_abort;
    logic [1:0]  seen_disable;
    logic        seen_abort;
    int          fail_count;
    int          num_checks;

    usb_legacy_smi_wake_regs dut_u (
        .clock             (clock),
        .resetn            (resetn),
        .clock_enable      (clock_enable),
        .reg_write         (reg_write),
        .reg_read          (reg_read),
        .reg_addr          (reg_addr),
        .reg_byte_en       (reg_byte_en),
        .reg_wdata         (reg_wdata),
        .reg_rdata         (reg_rdata),
        .usb_irq           (usb_irq),
        .trap_event        (trap_event),
        .port_wake_event   (port_wake_event),
        .port_enabled_live (port_enabled_live),
        .smi_request       (smi_request),
        .wake_request      (wake_request),
        .port_disable      (port_disable),
        .transfer_abort    (transfer_abort)
    );

    // Free-running 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%08h expected=%08h", $time, seen, exp);
        end
    endtask

    // Idle cycles, inputs change only on the falling edge
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Whole-word write held over one rising edge
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        @(negedge clock);
        reg_write   = 1'b1;
        reg_addr    = addr;
        reg_wdata   = data;
        reg_byte_en = 2'h3;
        @(negedge clock);
        reg_write = 1'b0;
    endtask

    // Read; data is registered on the edge that takes the strobe
    task automatic rd(input logic [7:0] addr, output logic [31:0] data);
        @(negedge clock);
        reg_read = 1'b1;
        reg_addr = addr;
        @(negedge clock);
        reg_read = 1'b0;
        data     = reg_rdata;
    endtask

    // Read and compare under a mask
    task automatic rdc(input logic [7:0] addr, input logic [31:0] mask,
                       input logic [31:0] exp);
        logic [31:0] d;
        rd(addr, d);
        check(d & mask, exp & mask);
    endtask

    // Final report and end of run
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [7:0]  addrs [10];
        logic [31:0] resets [10];
        addrs  = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h0C, 8'h10, 8'h12, 8'h18, 8'hC4, 8'h14};
        resets = '{32'h0, 32'h20, 32'h0, 32'h0, 32'h40, 32'h80, 32'h80, 32'h0, 32'h0, 32'h0};
        fail_count = 0;
        num_checks = 0;
        clock_enable = 1'b1;
        resetn = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_byte_en = 2'h3;
        reg_wdata = 32'h0;
        usb_irq = 1'b0;
        trap_event = 4'h0;
        port_wake_event = 2'h0;
        port_enabled_live = 2'h0;
        idle(8);
        resetn = 1'b1;

        // Reset values of the map, unmapped hole reads zero
        for (int i = 0; i < 10; i++) begin
            rdc(addrs[i], 32'hFFFF, resets[i]);
        end
        check({31'h0, smi_request}, 32'h0);

        // Frame list base holds a full word; frame number refuses a byte write
        wr(OFS_FRAME_LIST_BASE, 32'hA5C3_0F00);
        rdc(OFS_FRAME_LIST_BASE, 32'hFFFF_FFFF, 32'hA5C3_0F00);
        wr(OFS_FRAME_NUMBER, 32'h1234);
        @(negedge clock);
        reg_write   = 1'b1;
        reg_addr    = OFS_FRAME_NUMBER;
        reg_wdata   = 32'h5678;
        reg_byte_en = 2'h1;
        @(negedge clock);
        reg_write   = 1'b0;
        reg_byte_en = 2'h3;
        rdc(OFS_FRAME_NUMBER, 32'hFFFF, 32'h1234);

        // Wake enables: reserved bits read zero, each bit serves its own port
        wr(OFS_WAKE_ENABLE, 32'hFF);
        rdc(OFS_WAKE_ENABLE, 32'hFF, 32'h03);
        wr(OFS_WAKE_ENABLE, 32'h02);
        port_wake_event = 2'h1;
        idle(6);
        check({31'h0, wake_request}, 32'h0);
        port_wake_event = 2'h2;
        idle(6);
        check({31'h0, wake_request}, 32'h1);
        port_wake_event = 2'h0;
        wr(OFS_WAKE_ENABLE, 32'h01);
        idle(4);
        port_wake_event = 2'h1;
        idle(6);
        check({31'h0, wake_request}, 32'h1);
        port_wake_event = 2'h0;
        wr(OFS_WAKE_ENABLE, 32'h00);

        // Each trap: status sets with enable off, SMI only once enabled, W1C clears
        for (int k = 0; k < 4; k++) begin
            wr(OFS_LEGACY_CTRL, 32'h0);
            trap_event = 4'h1 << k;
            idle(8);
            trap_event = 4'h0;
            rdc(OFS_LEGACY_CTRL, 32'h0F00, 32'h100 << k);
            check({31'h0, smi_request}, 32'h0);
            wr(OFS_LEGACY_CTRL, 32'h1 << k);
            idle(3);
            check({31'h0, smi_request}, 32'h1);
            wr(OFS_LEGACY_CTRL, (32'h100 << k) | (32'h1 << k));
            idle(3);
            check({31'h0, smi_request}, 32'h0);
            rdc(OFS_LEGACY_CTRL, 32'h0F1F, 32'h1 << k);
        end

        // Controller interrupt, disabled then enabled; status records it
        wr(OFS_LEGACY_CTRL, 32'h0F);
        usb_irq = 1'b1;
        idle(3);
        check({31'h0, smi_request}, 32'h0);
        wr(OFS_LEGACY_CTRL, 32'h10);
        idle(2);
        check({31'h0, smi_request}, 32'h1);
        usb_irq = 1'b0;
        wr(OFS_LEGACY_CTRL, 32'h0);
        rdc(OFS_HOST_STATUS, 32'h0001, 32'h0001);
        wr(OFS_HOST_STATUS, 32'hFFFF);
        rdc(OFS_HOST_STATUS, 32'hFFFF, 32'h0020);
        idle(3);
        check({31'h0, smi_request}, 32'h0);

        // Port enable reads back the live port state
        wr(OFS_PORT_A_SC, 32'h0004);
        idle(4);
        rdc(OFS_PORT_A_SC, 32'h0004, 32'h0);
        port_enabled_live = 2'h3;
        idle(4);
        rdc(OFS_PORT_A_SC, 32'h0004, 32'h0004);

        // Port reset on the second port disables that port alone
        wr(OFS_PORT_B_SC, 32'h0204);
        idle(2);
        check({30'h0, port_disable}, 32'h2);
        check({31'h0, transfer_abort}, 32'h1);
        rdc(OFS_PORT_B_SC, 32'h0004, 32'h0);
        wr(OFS_PORT_B_SC, 32'h0000);
        idle(2);
        check({30'h0, port_disable}, 32'h0);

        // Host reset ends transfers, disables ports, clears resume and port bits
        wr(OFS_HOST_COMMAND, 32'h0010);
        rdc(OFS_HOST_COMMAND, 32'h0010, 32'h0010);
        seen_disable = 2'h0;
        seen_abort = 1'b0;
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr = OFS_HOST_COMMAND;
        reg_wdata = 32'h0012;
        for (int c = 0; c < 6; c++) begin
            @(negedge clock);
            reg_write = 1'b0;
            seen_disable = seen_disable | port_disable;
            seen_abort = seen_abort | transfer_abort;
        end
        check({30'h0, seen_disable}, 32'h3);
        check({31'h0, seen_abort}, 32'h1);
        rdc(OFS_HOST_COMMAND, 32'h0010, 32'h0);
        rdc(OFS_PORT_A_SC, 32'h1044, 32'h0);
        rdc(OFS_PORT_B_SC, 32'h1044, 32'h0);

        // Global reset is held by software: resume drops, ports stay disabled
        wr(OFS_HOST_COMMAND, 32'h0014);
        rdc(OFS_HOST_COMMAND, 32'h0014, 32'h0004);
        check({30'h0, port_disable}, 32'h3);
        wr(OFS_HOST_COMMAND, 32'h0000);
        idle(2);
        check({30'h0, port_disable}, 32'h0);
        print_verdict();
    end
endmodule
